//--- dv/rlbs_tb_top.sv
// self-checking bench for the lane status and raw bypass block
`timescale 1ns/1ps
module rlbs_tb_top
	import rlbs_pkg::*;
;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic        pready, pslverr, irq, rerr, rd, en = 1'b0, pulse;
	rlbs_word_t  rx_word [12], raw_word [12], last;
	logic [11:0] vld = '0, err, lock, avail, rvld, disc, sflg, ovr, flk;
	logic [7:0]  mub = 8'h00, mub_out;
	logic        resync = 1'b0;
	int          cnt, miscompares = 0, comparisons = 0;

	always #2.5 pclk = ~pclk;
	initial foreach (rx_word[i]) rx_word[i] = '0;

	rlbs_top #(.MF_LEN(16)) rlbs_top_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .rx_word(rx_word), .rx_word_valid(vld),
		.rx_mubits(mub), .raw_lane_read_request(rd),
		.raw_resync_request(resync), .ctl_word_type_error(err),
		.multiuse_control_bits(mub_out), .multiuse_bits_refresh_pulse(pulse),
		.word_boundary_locked(lock), .raw_lane_available(avail),
		.raw_lane_word(raw_word), .raw_lane_word_valid(rvld),
		.raw_lane_discard_flag(disc), .raw_lane_frame_sync_flag(sflg),
		.raw_lane_buffer_overrun(ovr), .raw_lane_frame_locked(flk));

	rlbs_user_model rlbs_user_model_inst (.pclk(pclk), .presetn(presetn),
		.en(en), .avail(avail), .valid(rvld), .word0(raw_word[0]),
		.rd_q(rd), .last_q(last), .cnt_q(cnt));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic finish_test;
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [65:0] e, input logic [65:0] g);
		comparisons++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 20 && pready !== 1'b1)
		begin
			miscompares++;
			finish_test();
		end
	endtask

	task automatic send(input logic [1:0] h, input logic [63:0] p, input int n);
		repeat (n)
		begin
			@(posedge pclk);
			vld <= '1;
			foreach (rx_word[i]) rx_word[i] <= {h, p};
		end
		@(posedge pclk);
		vld <= '0;
		#1;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_lock;
		send(2'h1, 64'h0, 63);
		chk("lock_63", 66'h0, lock);
		send(2'h1, 64'h0, 1);
		chk("lock_64", 66'hFFF, lock);
		chk("overrun", 66'hFFF, ovr);
	endtask

	task automatic t_resync;
		@(posedge pclk);
		resync <= 1'b1;
		@(posedge pclk);
		resync <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
		chk("lock_resync", 66'h0, lock);
		chk("ovr_resync", 66'h0, ovr);
		send(2'h2, {6'h1E, 58'h0}, 64);
		chk("lock_sync_words", 66'hFFF, lock);
	endtask

	task automatic t_read;
		int c;
		en <= 1'b1;
		repeat (6) @(posedge pclk);
		c = cnt;
		send(2'h1, 64'hA5C3_0F1E_2D4B_6987, 1);
		repeat (4) @(posedge pclk);
		#1;
		chk("read_count", 66'(c + 1), 66'(cnt));
		chk("read_word", {2'h1, 64'hA5C3_0F1E_2D4B_6987}, last);
		chk("avail_drained", 66'h0, avail);
		chk("discard_unframed", 66'hFFF, disc);
	endtask

	task automatic t_bad_type;
		int n;
		apb(1'b0, 8'h04, 32'h0);
		chk("irq_masked", 66'h0, irq);
		apb(1'b1, 8'h0C, 32'hF);
		apb(1'b1, 8'h08, 32'h1);
		send(2'h2, {6'h11, 58'h0}, 1);
		n = 0;
		while (err !== 12'hFFF && n < 4)
		begin
			@(posedge pclk);
			#1;
			n++;
		end
		chk("bad_type", 66'hFFF, err);
		@(posedge pclk);
		#1;
		chk("bad_type_clear", 66'h0, err);
		repeat (2) @(posedge pclk);
		#1;
		chk("irq_set", 66'h1, irq);
		apb(1'b0, 8'h04, 32'h0);
		chk("status_bad", 66'h1, rdat[0]);
		apb(1'b1, 8'h0C, 32'h1);
		repeat (2) @(posedge pclk);
		#1;
		chk("irq_clear", 66'h0, irq);
	endtask

	task automatic t_mub;
		@(posedge pclk);
		mub <= 8'h5A;
		@(posedge pclk);
		#1;
		chk("mub_pulse", 66'h1, pulse);
		chk("mub_value", 66'h5A, mub_out);
		@(posedge pclk);
		#1;
		chk("mub_single", 66'h0, pulse);
	endtask

	task automatic t_frame;
		repeat (4)
		begin
			send(2'h2, {6'h1E, 58'h0}, 1);
			send(2'h1, 64'h0, 15);
		end
		chk("frame_lock", 66'hFFF, flk);
		send(2'h2, {6'h1E, 58'h0}, 1);
		repeat (4) @(posedge pclk);
		#1;
		chk("sync_flag", 66'hFFF, sflg);
		chk("discard_framed", 66'h0, disc);
	endtask

	task automatic t_ctrl;
		apb(1'b1, 8'h00, 32'h0);
		send(2'h1, 64'h0, 1);
		chk("bypass_off_avail", 66'h0, avail);
		apb(1'b1, 8'h00, 32'h3);
		repeat (2) @(posedge pclk);
		#1;
		chk("ctrl_resync_lock", 66'h0, lock);
		chk("ctrl_resync_frame", 66'h0, flk);
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl_back", 66'h1, rdat);
	endtask

	task automatic t_regs;
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl_rst", 66'h1, rdat);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped_err", 66'h1, rerr);
		chk("unmapped_data", 66'h0, rdat);
	endtask

	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_lock();
		t_resync();
		t_read();
		t_bad_type();
		t_mub();
		t_frame();
		t_ctrl();
		finish_test();
	end
endmodule

//--- dv/rlbs_user_model.sv
// user fabric model that drains raw lane words
`timescale 1ns/1ps
module rlbs_user_model
	import rlbs_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        en,
	input  wire logic [11:0] avail,
	input  wire logic [11:0] valid,
	input  wire rlbs_word_t  word0,
	output logic             rd_q,
	output rlbs_word_t       last_q,
	output int               cnt_q
);
	// one read every other cycle, so a stale available bit is never used
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			rd_q <= 1'b0;
		else
			rd_q <= en && (avail != '0) && !rd_q;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			cnt_q <= 0;
			last_q <= '0;
		end
		else if (valid[0])
		begin
			cnt_q <= cnt_q + 1;
			last_q <= word0;
		end
endmodule

//--- inc/rlbs_pkg.sv
// types shared by the lane status and bypass logic
package rlbs_pkg;

	typedef logic [65:0] rlbs_word_t;

	typedef enum logic [1:0] {
		MF_HUNT,
		MF_VERIFY,
		MF_LOCKED
	} rlbs_mf_state_t;

endpackage

//--- inc/rlbs_regs.svh
// register map, field positions, reset values and timing counts
`ifndef RLBS_REGS_SVH
`define RLBS_REGS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define RLBS_LANES          12
`define RLBS_MUB_W          8
`define RLBS_ADDR_W         8

// ----------------------------------------------------------------
// word lock and metaframe counts
// ----------------------------------------------------------------
`define RLBS_LOCK_GOOD_LAST 7'h3F
`define RLBS_LOCK_WIN_LAST  6'h3F
`define RLBS_LOCK_BAD_LAST  5'h0F
`define RLBS_LOCK_GOOD_MIN  8'h40
`define RLBS_MF_LEN         2048
`define RLBS_MF_GOOD_LAST   3'h3

// ----------------------------------------------------------------
// framing header and control word block types
// ----------------------------------------------------------------
`define RLBS_HDR_CTL        2'h2
`define RLBS_TYPE_SYNC      6'h1E
`define RLBS_TYPE_SCRAM     6'h0A
`define RLBS_TYPE_SKIP      6'h06
`define RLBS_TYPE_DIAG      6'h19

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define RLBS_CTRL_OFS       8'h00
`define RLBS_INT_STAT_OFS   8'h04
`define RLBS_INT_EN_OFS     8'h08
`define RLBS_INT_CLR_OFS    8'h0C
`define RLBS_WORD_LOCK_OFS  8'h10
`define RLBS_FRAME_LOCK_OFS 8'h14
`define RLBS_BAD_TYPE_OFS   8'h18
`define RLBS_MUBITS_OFS     8'h1C
`define RLBS_OVERRUN_OFS    8'h20

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define RLBS_CTRL_BYPASS    0
`define RLBS_CTRL_RESYNC    1
`define RLBS_CTRL_RST       1'h1
`define RLBS_EV_BAD_TYPE    0
`define RLBS_EV_MUB_REFRESH 1
`define RLBS_EV_OVERRUN     2
`define RLBS_EV_LOCK_LOST   3
`define RLBS_EV_W           4
`define RLBS_INT_EN_RST     4'h0

`endif

//--- rtl/rlbs_lane.sv
// one receive lane: word lock, metaframe lock, type check, raw buffer
`timescale 1ns/1ps
`include "rlbs_regs.svh"

module rlbs_lane
	import rlbs_pkg::*;
#(
	parameter int MF_LEN = `RLBS_MF_LEN
)(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       resync,
	input  wire logic       cap_en,
	input  wire logic       rd,
	input  wire rlbs_word_t in_word,
	input  wire logic       in_valid,
	output rlbs_word_t      word_q,
	output logic            valid_q,
	output logic            disc_q,
	output logic            sync_flag_q,
	output logic            avail_q,
	output logic            overflow_q,
	output logic            word_lock_q,
	output logic            mf_lock_q,
	output logic            bad_type_q
);

	localparam logic [15:0] MF_LAST = 16'(MF_LEN - 1);

	function automatic logic type_legal(input rlbs_word_t w);
		type_legal = w[63] || w[63:58] == `RLBS_TYPE_SYNC
			|| w[63:58] == `RLBS_TYPE_SCRAM
			|| w[63:58] == `RLBS_TYPE_SKIP
			|| w[63:58] == `RLBS_TYPE_DIAG;
	endfunction

	function automatic logic is_sync(input rlbs_word_t w);
		is_sync = w[65:64] == `RLBS_HDR_CTL
			&& w[63:58] == `RLBS_TYPE_SYNC;
	endfunction

	logic           hdr_ok;
	logic           is_ctl;
	logic           sync_in;
	logic           at_end;
	logic           discard;
	logic           bad_cond;
	logic [6:0]     good_cnt_q;
	logic [5:0]     win_cnt_q;
	logic [4:0]     bad_cnt_q;
	rlbs_mf_state_t mf_st_q;
	logic [15:0]    mf_pos_q;
	logic [2:0]     mf_good_q;
	rlbs_word_t     buf_q;
	logic           buf_disc_q;
	logic           buf_sync_q;
	logic [7:0]     run_h_q;

	assign hdr_ok   = in_word[65] ^ in_word[64];
	assign is_ctl   = in_word[65:64] == `RLBS_HDR_CTL;
	assign sync_in  = in_valid && is_sync(in_word);
	assign at_end   = mf_pos_q == MF_LAST;
	assign discard  = !word_lock_q || !mf_lock_q || !hdr_ok;
	assign bad_cond = in_valid && word_lock_q && is_ctl
		&& !type_legal(in_word);

	// ----------------------------------------------------------------
	// word boundary lock from framing headers only
	// ----------------------------------------------------------------
	// in lock, 16 bad headers inside a 64-word window drop it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			word_lock_q <= 1'b0;
			good_cnt_q  <= '0;
			win_cnt_q   <= '0;
			bad_cnt_q   <= '0;
		end
		else if (resync)
		begin
			word_lock_q <= 1'b0;
			good_cnt_q  <= '0;
			win_cnt_q   <= '0;
			bad_cnt_q   <= '0;
		end
		else if (in_valid && !word_lock_q)
		begin
			if (!hdr_ok)
				good_cnt_q <= '0;
			else if (good_cnt_q == `RLBS_LOCK_GOOD_LAST)
			begin
				word_lock_q <= 1'b1;
				good_cnt_q  <= '0;
				win_cnt_q   <= '0;
				bad_cnt_q   <= '0;
			end
			else
				good_cnt_q <= good_cnt_q + 7'h01;
		end
		else if (in_valid)
		begin
			if (!hdr_ok && bad_cnt_q == `RLBS_LOCK_BAD_LAST)
				word_lock_q <= 1'b0;
			if (win_cnt_q == `RLBS_LOCK_WIN_LAST)
			begin
				win_cnt_q <= '0;
				bad_cnt_q <= '0;
			end
			else
			begin
				win_cnt_q <= win_cnt_q + 6'h01;
				bad_cnt_q <= bad_cnt_q + {4'h0, !hdr_ok};
			end
		end
	end

	// ----------------------------------------------------------------
	// metaframe lock: four sync words at the metaframe period
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mf_st_q   <= MF_HUNT;
			mf_lock_q <= 1'b0;
			mf_pos_q  <= '0;
			mf_good_q <= '0;
		end
		else if (resync || !word_lock_q)
		begin
			mf_st_q   <= MF_HUNT;
			mf_lock_q <= 1'b0;
			mf_pos_q  <= '0;
			mf_good_q <= '0;
		end
		else if (in_valid)
		begin
			case (mf_st_q)
				MF_HUNT:
					if (sync_in)
					begin
						mf_st_q   <= MF_VERIFY;
						mf_pos_q  <= '0;
						mf_good_q <= 3'h1;
					end
				MF_VERIFY, MF_LOCKED:
					if (at_end != sync_in)
					begin
						mf_st_q   <= MF_HUNT;
						mf_lock_q <= 1'b0;
					end
					else if (at_end)
					begin
						mf_pos_q <= '0;
						if (mf_st_q == MF_VERIFY
							&& mf_good_q == `RLBS_MF_GOOD_LAST)
						begin
							mf_st_q   <= MF_LOCKED;
							mf_lock_q <= 1'b1;
						end
						else if (mf_st_q == MF_VERIFY)
							mf_good_q <= mf_good_q + 3'h1;
					end
					else
						mf_pos_q <= mf_pos_q + 16'h0001;
				default:
				begin
					mf_st_q   <= MF_HUNT;
					mf_lock_q <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// block type check, one cycle per offending word
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bad_type_q <= 1'b0;
		else
			bad_type_q <= bad_cond;
	end

	// ----------------------------------------------------------------
	// one-word lane buffer; newest word wins on overrun
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			buf_q      <= '0;
			buf_disc_q <= 1'b0;
			buf_sync_q <= 1'b0;
			avail_q    <= 1'b0;
			overflow_q <= 1'b0;
		end
		else if (resync)
		begin
			avail_q    <= 1'b0;
			overflow_q <= 1'b0;
		end
		else if (cap_en && in_valid)
		begin
			buf_q      <= in_word;
			buf_disc_q <= discard;
			buf_sync_q <= sync_in && word_lock_q;
			avail_q    <= 1'b1;
			if (avail_q && !rd)
				overflow_q <= 1'b1;
		end
		else if (rd)
			avail_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			word_q      <= '0;
			valid_q     <= 1'b0;
			disc_q      <= 1'b0;
			sync_flag_q <= 1'b0;
		end
		else
		begin
			valid_q <= rd && avail_q;
			if (rd && avail_q)
			begin
				word_q      <= buf_q;
				disc_q      <= buf_disc_q;
				sync_flag_q <= buf_sync_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			run_h_q <= '0;
		else if (resync || (in_valid && !hdr_ok))
			run_h_q <= '0;
		else if (in_valid && run_h_q != 8'hFF)
			run_h_q <= run_h_q + 8'h01;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence read_s;
		rd && avail_q;
	endsequence

	lock_run_a: assert property (
		$rose(word_lock_q) |-> run_h_q >= `RLBS_LOCK_GOOD_MIN)
		else $error("word lock before 64 good headers");
	bad_type_a: assert property (
		bad_cond |=> bad_type_q)
		else $error("bad type not flagged");
	bad_clear_a: assert property (
		!bad_cond |=> !bad_type_q)
		else $error("bad type flag held");
	read_word_a: assert property (
		read_s |=> valid_q && word_q == $past(buf_q))
		else $error("read word mismatch");
	valid_cause_a: assert property (
		valid_q |-> $past(avail_q) && $past(rd))
		else $error("valid without read");
	overrun_a: assert property (
		cap_en && in_valid && avail_q && !rd && !resync
		|=> overflow_q)
		else $error("overrun not flagged");
	sync_flag_a: assert property (
		valid_q && sync_flag_q |-> is_sync(word_q))
		else $error("sync flag on non sync word");
	discard_a: assert property (
		valid_q && !disc_q |-> word_q[65] != word_q[64])
		else $error("bad header not discarded");
	mf_lock_a: assert property (
		$rose(mf_lock_q) |-> $past(sync_in) && word_lock_q)
		else $error("metaframe lock without sync word");

endmodule

//--- rtl/rlbs_top.sv
// receive lane status and raw lane bypass with APB registers
`timescale 1ns/1ps
`include "rlbs_regs.svh"

// What this block does
// - Flag each lane receiving an illegal metaframe control word block type.
// - Pulse refresh output one cycle whenever multi-use control bits change.
// - Set lane word lock only after 64 consecutive valid framing headers.
// - Word lock depends only on framing headers, not sync or scrambler words.
// - Raw resync request restarts word boundary search on every lane.
// - Per-lane available bit shows a readable word is held.
// - Each lane presents its own 66-bit output word.
// - Per-lane valid bit qualifies the lane output word.
// - Per-lane flag marks badly framed words the user must discard.
// - Per-lane flag marks metaframe synchronization words.
// - Per-lane overflow flag shows that lane's buffer overran.
// - Per-lane flag shows metaframe lock, ready for alignment.

module rlbs_top
	import rlbs_pkg::*;
#(
	parameter int LANES  = `RLBS_LANES,
	parameter int MF_LEN = `RLBS_MF_LEN
)(
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [`RLBS_ADDR_W-1:0] paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	output logic                         irq,
	input  wire rlbs_word_t              rx_word [LANES],
	input  wire logic [LANES-1:0]        rx_word_valid,
	input  wire logic [`RLBS_MUB_W-1:0]  rx_mubits,
	input  wire logic                    raw_lane_read_request,
	input  wire logic                    raw_resync_request,
	output logic [LANES-1:0]             ctl_word_type_error,
	output logic [`RLBS_MUB_W-1:0]       multiuse_control_bits,
	output logic                         multiuse_bits_refresh_pulse,
	output logic [LANES-1:0]             word_boundary_locked,
	output logic [LANES-1:0]             raw_lane_available,
	output rlbs_word_t                   raw_lane_word [LANES],
	output logic [LANES-1:0]             raw_lane_word_valid,
	output logic [LANES-1:0]             raw_lane_discard_flag,
	output logic [LANES-1:0]             raw_lane_frame_sync_flag,
	output logic [LANES-1:0]             raw_lane_buffer_overrun,
	output logic [LANES-1:0]             raw_lane_frame_locked
);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic addr_mapped(input logic [7:0] a);
		case (a)
			`RLBS_CTRL_OFS, `RLBS_INT_STAT_OFS, `RLBS_INT_EN_OFS,
			`RLBS_INT_CLR_OFS, `RLBS_WORD_LOCK_OFS,
			`RLBS_FRAME_LOCK_OFS, `RLBS_BAD_TYPE_OFS,
			`RLBS_MUBITS_OFS, `RLBS_OVERRUN_OFS:
				addr_mapped = 1'b1;
			default:
				addr_mapped = 1'b0;
		endcase
	endfunction

	// all control fields sit in byte lane 0
	function automatic logic [3:0] strb_merge(input logic [3:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		strb_merge = st[0] ? wd[3:0] : old;
	endfunction

	logic                    setup;
	logic                    wr_acc;
	logic                    bypass_en_q;
	logic                    resync_q;
	logic [`RLBS_EV_W-1:0]   int_en_q;
	logic [`RLBS_EV_W-1:0]   status_q;
	logic [`RLBS_EV_W-1:0]   status_d;
	logic [`RLBS_EV_W-1:0]   ev;
	logic [`RLBS_EV_W-1:0]   clr;
	logic [`RLBS_MUB_W-1:0]  mub_q;
	logic [LANES-1:0]        lock_prev_q;
	logic [LANES-1:0]        ovr_prev_q;
	logic                    lane_rd;
	logic [31:0]             rd_mux;

	assign setup  = psel && !penable;
	assign wr_acc = psel && penable && pready && pwrite && !pslverr;
	assign lane_rd = raw_lane_read_request && bypass_en_q;

	// ----------------------------------------------------------------
	// lanes
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < LANES; g++)
		begin : gen_lane
			rlbs_lane #(
				.MF_LEN(MF_LEN)
			) u_lane (
				.pclk        (pclk),
				.presetn     (presetn),
				.resync      (resync_q),
				.cap_en      (bypass_en_q),
				.rd          (lane_rd),
				.in_word     (rx_word[g]),
				.in_valid    (rx_word_valid[g]),
				.word_q      (raw_lane_word[g]),
				.valid_q     (raw_lane_word_valid[g]),
				.disc_q      (raw_lane_discard_flag[g]),
				.sync_flag_q (raw_lane_frame_sync_flag[g]),
				.avail_q     (raw_lane_available[g]),
				.overflow_q  (raw_lane_buffer_overrun[g]),
				.word_lock_q (word_boundary_locked[g]),
				.mf_lock_q   (raw_lane_frame_locked[g]),
				.bad_type_q  (ctl_word_type_error[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// multi-use control bits
	// ----------------------------------------------------------------
	// one clock here, so the retransmit clock choice collapses to pclk
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mub_q                       <= '0;
			multiuse_bits_refresh_pulse <= 1'b0;
		end
		else
		begin
			mub_q                       <= rx_mubits;
			multiuse_bits_refresh_pulse <= rx_mubits != mub_q;
		end
	end

	assign multiuse_control_bits = mub_q;

	// ----------------------------------------------------------------
	// control: bypass enable and resync pulse
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bypass_en_q <= `RLBS_CTRL_RST;
		else if (wr_acc && paddr == `RLBS_CTRL_OFS && pstrb[0])
			bypass_en_q <= pwdata[`RLBS_CTRL_BYPASS];
	end

	// user request and software bit merge into one restart pulse
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			resync_q <= 1'b0;
		else
			resync_q <= raw_resync_request
				|| (wr_acc && paddr == `RLBS_CTRL_OFS && pstrb[0]
				&& pwdata[`RLBS_CTRL_RESYNC]);
	end

	// ----------------------------------------------------------------
	// interrupt events
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lock_prev_q <= '0;
			ovr_prev_q  <= '0;
		end
		else
		begin
			lock_prev_q <= word_boundary_locked;
			ovr_prev_q  <= raw_lane_buffer_overrun;
		end
	end

	always_comb
	begin
		ev = '0;
		ev[`RLBS_EV_BAD_TYPE]    = |ctl_word_type_error;
		ev[`RLBS_EV_MUB_REFRESH] = multiuse_bits_refresh_pulse;
		ev[`RLBS_EV_OVERRUN]     = |(raw_lane_buffer_overrun & ~ovr_prev_q);
		ev[`RLBS_EV_LOCK_LOST]   = |(lock_prev_q & ~word_boundary_locked);
		clr = '0;
		if (wr_acc && paddr == `RLBS_INT_CLR_OFS && pstrb[0])
			clr = pwdata[`RLBS_EV_W-1:0];
		// a new event beats a clear in the same cycle
		status_d = (status_q & ~clr) | ev;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_q <= '0;
		else
			status_q <= status_d;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_en_q <= `RLBS_INT_EN_RST;
		else if (wr_acc && paddr == `RLBS_INT_EN_OFS)
			int_en_q <= strb_merge(int_en_q, pwdata, pstrb);
	end

	// irq lags a change of the enable by one cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(status_d & int_en_q);
	end

	// ----------------------------------------------------------------
	// APB slave: one wait-free access phase, data latched at setup
	// ----------------------------------------------------------------
	always_comb
	begin
		rd_mux = '0;
		case (paddr)
			`RLBS_CTRL_OFS:
				rd_mux[`RLBS_CTRL_BYPASS] = bypass_en_q;
			`RLBS_INT_STAT_OFS:
				rd_mux[`RLBS_EV_W-1:0] = status_q;
			`RLBS_INT_EN_OFS:
				rd_mux[`RLBS_EV_W-1:0] = int_en_q;
			`RLBS_WORD_LOCK_OFS:
				rd_mux[LANES-1:0] = word_boundary_locked;
			`RLBS_FRAME_LOCK_OFS:
				rd_mux[LANES-1:0] = raw_lane_frame_locked;
			`RLBS_BAD_TYPE_OFS:
				rd_mux[LANES-1:0] = ctl_word_type_error;
			`RLBS_MUBITS_OFS:
				rd_mux[`RLBS_MUB_W-1:0] = mub_q;
			`RLBS_OVERRUN_OFS:
				rd_mux[LANES-1:0] = raw_lane_buffer_overrun;
			default:
				rd_mux = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end
		else
		begin
			pready <= setup;
			if (setup)
			begin
				pslverr <= !addr_mapped(paddr);
				prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
			end
			else
				pslverr <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence apb_setup_s;
		psel && !penable;
	endsequence

	refresh_on_change_a: assert property (
		rx_mubits != mub_q |=> multiuse_bits_refresh_pulse
			&& multiuse_control_bits == $past(rx_mubits))
		else $error("missing refresh pulse");
	refresh_single_a: assert property (
		multiuse_bits_refresh_pulse && rx_mubits == mub_q
		|=> !multiuse_bits_refresh_pulse)
		else $error("refresh pulse too long");
	resync_clears_a: assert property (
		raw_resync_request |=> resync_q ##1 word_boundary_locked == '0)
		else $error("resync did not drop word lock");
	apb_answer_a: assert property (
		apb_setup_s |=> pready ##1 !pready)
		else $error("apb answer timing");
	set_wins_a: assert property (
		ev[`RLBS_EV_BAD_TYPE] |=> status_q[`RLBS_EV_BAD_TYPE])
		else $error("event lost against clear");
	irq_level_a: assert property (
		ev[`RLBS_EV_BAD_TYPE] && int_en_q[`RLBS_EV_BAD_TYPE] |=> irq)
		else $error("enabled event without irq");
	read_gate_a: assert property (
		!bypass_en_q [*2] |-> raw_lane_word_valid == '0)
		else $error("lane word valid while bypass off");

endmodule
